// file: logic/iopm_defines.svh
// Register offsets, image bit positions, reset values and timing counts of the image mapper.
`ifndef IOPM_DEFINES_SVH
`define IOPM_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the Wishbone bus.
`define IOPM_OFS_IN0        8'h00
`define IOPM_OFS_IN1        8'h04
`define IOPM_OFS_OUT0       8'h08
`define IOPM_OFS_OUT1       8'h0c
`define IOPM_OFS_STATUS     8'h10
`define IOPM_OFS_MASK       8'h14

////////////////////////////////////////////////////////////////////////////////
// Image sizes in bits and the analog channel count.
`define IOPM_IN_BITS        56
`define IOPM_OUT_BITS       48
`define IOPM_ANA_CH         2
`define IOPM_ANA_RAW_W      24
`define IOPM_ANA_DATA_W     16

////////////////////////////////////////////////////////////////////////////////
// Input image positions: analog words first, then digital bits packed.
`define IOPM_IN_ANA_POS     0
`define IOPM_IN_D8_POS      32
`define IOPM_IN_IO8_POS     40
`define IOPM_IN_D4_POS      48

////////////////////////////////////////////////////////////////////////////////
// Output image positions in physical module order.
`define IOPM_OUT_O8_POS     0
`define IOPM_OUT_D8_POS     8
`define IOPM_OUT_O16_POS    16
`define IOPM_OUT_IO8_POS    32
`define IOPM_OUT_D4_POS     40
`define IOPM_OUT_USED       48'h0fff_ffff_ffff

////////////////////////////////////////////////////////////////////////////////
// Status and mask layout, reset values and bus timing.
`define IOPM_ST_D8_POS      0
`define IOPM_ST_D4_POS      8
`define IOPM_ST_W           12
`define IOPM_RST_OUT        48'h0000_0000_0000
`define IOPM_RST_MASK       12'h000
`define IOPM_ACK_CYCLES     1

`endif

// file: logic/iopm_pkg.sv
// Types shared by the image mapper modules.
package iopm_pkg;

	typedef enum {
		IOPM_REG_IN0,
		IOPM_REG_IN1,
		IOPM_REG_OUT0,
		IOPM_REG_OUT1,
		IOPM_REG_STATUS,
		IOPM_REG_MASK,
		IOPM_REG_NONE
	} iopm_reg_t;

	typedef logic [31:0] iopm_word_t;

endpackage : iopm_pkg

// file: logic/iopm_diag_flags.sv
// Per-channel fault flag capture with a rising-edge event for each channel.
`timescale 1ns/1ps
module iopm_diag_flags #(
	parameter int N = 4
) (
	input  wire logic         sys_clk_i,
	input  wire logic         reset_i,
	input  wire logic [N-1:0] overload_i,
	input  wire logic [N-1:0] short_i,
	input  wire logic [N-1:0] open_i,
	output logic      [N-1:0] flag_o,
	output logic      [N-1:0] event_o
);

	logic [N-1:0] flag_d;
	logic [N-1:0] flag_q;
	logic [N-1:0] event_d;
	logic [N-1:0] event_q;

	////////////////////////////////////////////////////////////////////////////////
	// A flag is one while any fault of its channel is present, zero otherwise.
	always_comb begin
		flag_d  = overload_i | short_i | open_i;
		event_d = flag_d & ~flag_q;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			flag_q  <= '0;
			event_q <= '0;
		end else begin
			flag_q  <= flag_d;
			event_q <= event_d;
		end
	end

	assign flag_o  = flag_q;
	assign event_o = event_q;

	AST_FLAG_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> flag_q == $past(overload_i | short_i | open_i))
		else $error("Diagnostic flag does not follow channel fault.");

endmodule : iopm_diag_flags

// file: logic/iopm_mapper.sv
// Process image mapper: analog words and digital module bits to Wishbone image registers.
`timescale 1ns/1ps
`include "iopm_defines.svh"
module iopm_mapper
	import iopm_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [47:0] ana_raw_i,
	input  wire logic [3:0]  d4_overload_i,
	input  wire logic [3:0]  d4_short_i,
	input  wire logic [3:0]  d4_open_i,
	input  wire logic [7:0]  d8_overload_i,
	input  wire logic [7:0]  d8_short_i,
	input  wire logic [7:0]  d8_open_i,
	input  wire logic [7:0]  io8_input_channel_level_i,
	output logic      [3:0]  d4_ctrl_o,
	output logic      [7:0]  d8_ctrl_o,
	output logic      [7:0]  o8_ctrl_o,
	output logic      [15:0] o16_ctrl_o,
	output logic      [7:0]  io8_ctrl_o,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic iopm_reg_t reg_decode(input logic [7:0] adr);
		case (adr)
			`IOPM_OFS_IN0:    reg_decode = IOPM_REG_IN0;
			`IOPM_OFS_IN1:    reg_decode = IOPM_REG_IN1;
			`IOPM_OFS_OUT0:   reg_decode = IOPM_REG_OUT0;
			`IOPM_OFS_OUT1:   reg_decode = IOPM_REG_OUT1;
			`IOPM_OFS_STATUS: reg_decode = IOPM_REG_STATUS;
			`IOPM_OFS_MASK:   reg_decode = IOPM_REG_MASK;
			default:          reg_decode = IOPM_REG_NONE;
		endcase
	endfunction : reg_decode

	function automatic iopm_word_t byte_merge(input iopm_word_t old_w, input iopm_word_t new_w,
		input logic [3:0] sel);
		iopm_word_t res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		byte_merge = res;
	endfunction : byte_merge

	////////////////////////////////////////////////////////////////////////////////
	// Diagnostic flag capture for the two diagnostic output modules.

	logic [3:0] d4_flag;
	logic [3:0] d4_event;
	logic [7:0] d8_flag;
	logic [7:0] d8_event;

	iopm_diag_flags #(
		.N (4)
	) u_diag4 (
		.sys_clk_i  (sys_clk_i),
		.reset_i    (reset_i),
		.overload_i (d4_overload_i),
		.short_i    (d4_short_i),
		.open_i     (d4_open_i),
		.flag_o     (d4_flag),
		.event_o    (d4_event)
	);

	iopm_diag_flags #(
		.N (8)
	) u_diag8 (
		.sys_clk_i  (sys_clk_i),
		.reset_i    (reset_i),
		.overload_i (d8_overload_i),
		.short_i    (d8_short_i),
		.open_i     (d8_open_i),
		.flag_o     (d8_flag),
		.event_o    (d8_event)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Input image. Analog words occupy the low bytes, so digital bits always
	// land behind them whatever modules are fitted.

	logic [`IOPM_IN_BITS-1:0] in_img_d;
	logic [`IOPM_IN_BITS-1:0] in_img_q;

	always_comb begin
		in_img_d = '0;
		for (int c = 0; c < `IOPM_ANA_CH; c++) begin
			// The top 8 status bits of each raw channel are dropped.
			in_img_d[`IOPM_IN_ANA_POS + c*16 +: 16] =
				ana_raw_i[c*`IOPM_ANA_RAW_W +: `IOPM_ANA_DATA_W];
		end
		in_img_d[`IOPM_IN_D8_POS +: 8]  = d8_flag;
		in_img_d[`IOPM_IN_IO8_POS +: 8] = io8_input_channel_level_i;
		in_img_d[`IOPM_IN_D4_POS +: 4]  = d4_flag;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			in_img_q <= '0;
		end else begin
			in_img_q <= in_img_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave and output image. A request is answered one cycle after it is
	// seen; a write lands on the same edge that raises ack.

	logic                      ack_d;
	logic                      ack_q;
	logic [31:0]               rdat_d;
	logic [31:0]               rdat_q;
	logic [`IOPM_OUT_BITS-1:0] out_img_d;
	logic [`IOPM_OUT_BITS-1:0] out_img_q;
	logic [`IOPM_ST_W-1:0]     mask_d;
	logic [`IOPM_ST_W-1:0]     mask_q;
	logic [`IOPM_ST_W-1:0]     st_q;
	logic                      take;
	logic                      wr;
	logic                      rd_status;
	iopm_reg_t                 sel_reg;
	iopm_word_t                merged;

	always_comb begin
		take      = wb_cyc_i && wb_stb_i && !ack_q;
		wr        = take && wb_we_i;
		sel_reg   = reg_decode(wb_adr_i);
		rd_status = take && !wb_we_i && (sel_reg == IOPM_REG_STATUS);
		ack_d     = take;
		rdat_d    = rdat_q;
		out_img_d = out_img_q;
		mask_d    = mask_q;
		merged    = '0;
		if (take && !wb_we_i) begin
			case (sel_reg)
				IOPM_REG_IN0:    rdat_d = in_img_q[31:0];
				IOPM_REG_IN1:    rdat_d = {8'h00, in_img_q[55:32]};
				IOPM_REG_OUT0:   rdat_d = out_img_q[31:0];
				IOPM_REG_OUT1:   rdat_d = {16'h0000, out_img_q[47:32]};
				IOPM_REG_STATUS: rdat_d = {20'h00000, st_q};
				IOPM_REG_MASK:   rdat_d = {20'h00000, mask_q};
				default:         rdat_d = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			case (sel_reg)
				IOPM_REG_OUT0: begin
					merged    = byte_merge(out_img_q[31:0], wb_dat_i, wb_sel_i);
					out_img_d = {out_img_q[47:32], merged};
				end
				IOPM_REG_OUT1: begin
					merged    = byte_merge({16'h0000, out_img_q[47:32]}, wb_dat_i, wb_sel_i);
					// Bits past the last module stay zero to keep whole bytes clean.
					out_img_d = {merged[15:0], out_img_q[31:0]} & `IOPM_OUT_USED;
				end
				IOPM_REG_MASK: begin
					merged = byte_merge({20'h00000, mask_q}, wb_dat_i, wb_sel_i);
					mask_d = merged[`IOPM_ST_W-1:0];
				end
				default: begin
					merged = '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ack_q     <= 1'b0;
			rdat_q    <= 32'h0000_0000;
			out_img_q <= `IOPM_RST_OUT;
			mask_q    <= `IOPM_RST_MASK;
		end else begin
			ack_q     <= ack_d;
			rdat_q    <= rdat_d;
			out_img_q <= out_img_d;
			mask_q    <= mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault events and interrupt. A new event in the cycle of a clearing read
	// survives, so no fault edge is lost between read and re-arm.

	logic [`IOPM_ST_W-1:0] st_d;
	logic [`IOPM_ST_W-1:0] ev;
	logic                  irq_d;
	logic                  irq_q;

	always_comb begin
		ev = '0;
		ev[`IOPM_ST_D8_POS +: 8] = d8_event;
		ev[`IOPM_ST_D4_POS +: 4] = d4_event;
		st_d  = (rd_status ? '0 : st_q) | ev;
		irq_d = |(st_d & mask_d);
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_q  <= '0;
			irq_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			irq_q <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, each a slice of a register.

	assign wb_ack_o   = ack_q;
	assign wb_dat_o   = rdat_q;
	assign irq_o      = irq_q;
	assign o8_ctrl_o  = out_img_q[`IOPM_OUT_O8_POS +: 8];
	assign d8_ctrl_o  = out_img_q[`IOPM_OUT_D8_POS +: 8];
	assign o16_ctrl_o = out_img_q[`IOPM_OUT_O16_POS +: 16];
	assign io8_ctrl_o = out_img_q[`IOPM_OUT_IO8_POS +: 8];
	assign d4_ctrl_o  = out_img_q[`IOPM_OUT_D4_POS +: 4];

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	AST_ACK_ONE_CYCLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus request not acked for exactly one cycle.");

	AST_D8_FLAG_IMAGE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!$past(reset_i) && !$past(reset_i, 2) |->
		in_img_q[`IOPM_IN_D8_POS] == $past(d8_overload_i[0] | d8_short_i[0] | d8_open_i[0], 2))
		else $error("Channel 1 fault flag missing from input image bit.");

	AST_D4_FLAG_IMAGE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> in_img_q[`IOPM_IN_D4_POS +: 4] == $past(d4_flag)
		&& in_img_q[55:52] == 4'h0)
		else $error("Four-channel flags misplaced in input image.");

	AST_ANA_LITTLE_END: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> in_img_q[7:0] == $past(ana_raw_i[7:0])
		&& in_img_q[15:8] == $past(ana_raw_i[15:8]))
		else $error("Analog word not little-endian in input image.");

	AST_ANA_NO_STATUS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> in_img_q[31:16] == $past(ana_raw_i[39:24]))
		else $error("Analog status bits leaked into input image.");

	AST_IO8_LEVELS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> in_img_q[`IOPM_IN_IO8_POS +: 8] == $past(io8_input_channel_level_i))
		else $error("Combined module input levels misplaced.");

	AST_O8_WRITE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == `IOPM_OFS_OUT0
		&& wb_sel_i[0] |=> o8_ctrl_o == $past(wb_dat_i[7:0]))
		else $error("Output byte write did not reach eight-channel module.");

	AST_O16_WRITE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == `IOPM_OFS_OUT0
		&& wb_sel_i[3:2] == 2'b11 |=> o16_ctrl_o == $past(wb_dat_i[31:16]))
		else $error("Sixteen-channel field write lost.");

	AST_OUT_PAD_ZERO: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		out_img_q[47:44] == 4'h0)
		else $error("Unused output image bits are not zero.");

	AST_EVENT_BEATS_CLEAR: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		rd_status && d8_event[0] |=> st_q[`IOPM_ST_D8_POS] ##1 1'b1)
		else $error("Fault event lost during status clear.");

	AST_IRQ_LEVEL: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> irq_o == |(st_q & mask_q))
		else $error("Interrupt does not match masked status.");

endmodule : iopm_mapper

// file: bench/iopm_node_model.sv
// Model of the I/O modules on the local bus, fed with the states the bench commands.
`timescale 1ns/1ps
module iopm_node_model (
	input  wire logic        sys_clk_i,
	input  wire logic [47:0] ana_set_i,
	input  wire logic [11:0] ovl_set_i,
	input  wire logic [11:0] shr_set_i,
	input  wire logic [11:0] opn_set_i,
	input  wire logic [7:0]  lvl_set_i,
	output logic      [47:0] ana_raw_o,
	output logic      [3:0]  d4_overload_o,
	output logic      [3:0]  d4_short_o,
	output logic      [3:0]  d4_open_o,
	output logic      [7:0]  d8_overload_o,
	output logic      [7:0]  d8_short_o,
	output logic      [7:0]  d8_open_o,
	output logic      [7:0]  io8_level_o
);
	// Modules update their pins on the clock, one cycle after the bench asks for it.
	// The analog raw value keeps its status byte, so the mapper must drop it itself.
	always_ff @(posedge sys_clk_i) begin
		ana_raw_o     <= ana_set_i;
		d8_overload_o <= ovl_set_i[7:0];
		d4_overload_o <= ovl_set_i[11:8];
		d8_short_o    <= shr_set_i[7:0];
		d4_short_o    <= shr_set_i[11:8];
		d8_open_o     <= opn_set_i[7:0];
		d4_open_o     <= opn_set_i[11:8];
		io8_level_o   <= lvl_set_i;
	end
endmodule : iopm_node_model

// file: bench/io_process_image_mapper_tb.sv
// Self-checking bench of the image mapper over Wishbone.
`timescale 1ns/1ps
`include "iopm_defines.svh"
module io_process_image_mapper_tb;
	logic        sys_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dw = 32'h0, rd, dat_o;
	logic        ack, irq;
	logic [47:0] ana_s = 48'h0, ana;
	logic [11:0] ovl_s = 12'h0, shr_s = 12'h0, opn_s = 12'h0;
	logic [7:0]  lvl_s = 8'h0, lvl, d8o, d8s, d8p, o8, d8c, io8c;
	logic [3:0]  d4o, d4s, d4p, d4c;
	logic [15:0] o16;
	logic [7:0]  p8 [3] = '{8'h81, 8'h42, 8'h24};
	logic [3:0]  p4 [3] = '{4'h1, 4'h2, 4'h8};
	int          n_mismatch = 0;
	int          samples_checked = 0;

	always #2.5 sys_clk_i = ~sys_clk_i;

	iopm_node_model i_node (.sys_clk_i(sys_clk_i), .ana_set_i(ana_s), .ovl_set_i(ovl_s),
		.shr_set_i(shr_s), .opn_set_i(opn_s), .lvl_set_i(lvl_s), .ana_raw_o(ana),
		.d4_overload_o(d4o), .d4_short_o(d4s), .d4_open_o(d4p), .d8_overload_o(d8o),
		.d8_short_o(d8s), .d8_open_o(d8p), .io8_level_o(lvl));

	iopm_mapper i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .ana_raw_i(ana), .d4_overload_i(d4o),
		.d4_short_i(d4s), .d4_open_i(d4p), .d8_overload_i(d8o), .d8_short_i(d8s),
		.d8_open_i(d8p), .io8_input_channel_level_i(lvl), .d4_ctrl_o(d4c),
		.d8_ctrl_o(d8c), .o8_ctrl_o(o8), .o16_ctrl_o(o16), .io8_ctrl_o(io8c), .irq_o(irq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	// Request is held until ack is sampled high; read data is taken at that same edge.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d; sel <= s;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk("ack", 32'(ack), 32'h1);
		rd = dat_o;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : xfer

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 4'hf);
		chk(what, rd, exp);
	endtask : rdchk

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : tick

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(20000);
		n_mismatch++;
		conclude();
	end

	initial begin
		tick(3);
		reset_i <= 1'b0;
		rdchk("out0 reset", `IOPM_OFS_OUT0, 32'h0);
		rdchk("out1 reset", `IOPM_OFS_OUT1, 32'h0);
		rdchk("mask reset", `IOPM_OFS_MASK, 32'h0);
		chk("ctrl reset", {o16, o8, d8c}, 32'h0);
		chk("ctrl reset hi", 32'({d4c, io8c}), 32'h0);
		// Analog words come first, low byte lowest, status byte hidden.
		ana_s <= 48'h5a_abcd_a5_1234;
		tick(4);
		rdchk("in0 analog", `IOPM_OFS_IN0, 32'habcd_1234);
		xfer(1'b1, `IOPM_OFS_OUT0, 32'hc3a5_5a81, 4'hf);
		tick(1);
		chk("o8", 32'(o8), 32'h81);
		chk("d8 ctrl", 32'(d8c), 32'h5a);
		chk("o16", 32'(o16), 32'hc3a5);
		xfer(1'b1, `IOPM_OFS_OUT0, 32'h0, 4'h1);
		rdchk("out0 byte", `IOPM_OFS_OUT0, 32'hc3a5_5a00);
		xfer(1'b1, `IOPM_OFS_OUT1, 32'hffff_ffff, 4'hf);
		tick(1);
		chk("io8 ctrl", 32'(io8c), 32'hff);
		chk("d4 ctrl", 32'(d4c), 32'hf);
		rdchk("out1", `IOPM_OFS_OUT1, 32'h0000_0fff);
		// Each fault kind alone must set the flag of exactly its channels.
		lvl_s <= 8'h3c;
		for (int k = 0; k < 3; k++) begin
			ovl_s <= (k == 0) ? {p4[k], p8[k]} : 12'h0;
			shr_s <= (k == 1) ? {p4[k], p8[k]} : 12'h0;
			opn_s <= (k == 2) ? {p4[k], p8[k]} : 12'h0;
			tick(5);
			rdchk("in1 flags", `IOPM_OFS_IN1, {12'h0, p4[k], 8'h3c, p8[k]});
		end
		opn_s <= 12'h0;
		tick(5);
		rdchk("in1 clear", `IOPM_OFS_IN1, 32'h0000_3c00);
		chk("irq masked", 32'(irq), 32'h0);
		rdchk("status", `IOPM_OFS_STATUS, 32'h0000_0be7);
		rdchk("status cleared", `IOPM_OFS_STATUS, 32'h0);
		// Only the masked-in channel may raise the interrupt.
		xfer(1'b1, `IOPM_OFS_MASK, 32'h0000_0001, 4'hf);
		rdchk("mask", `IOPM_OFS_MASK, 32'h0000_0001);
		opn_s <= 12'h100;
		tick(6);
		chk("irq other", 32'(irq), 32'h0);
		shr_s <= 12'h001;
		tick(6);
		chk("irq set", 32'(irq), 32'h1);
		rdchk("status two", `IOPM_OFS_STATUS, 32'h0000_0101);
		tick(2);
		chk("irq after read", 32'(irq), 32'h0);
		// Read-only and unmapped places ignore writes.
		xfer(1'b1, `IOPM_OFS_IN1, 32'hffff_ffff, 4'hf);
		rdchk("in1 ro", `IOPM_OFS_IN1, 32'h0001_3c01);
		xfer(1'b1, 8'h18, 32'hffff_ffff, 4'hf);
		rdchk("unmapped", 8'h18, 32'h0);
		// A fault edge in the very cycle of a clearing read must stay set.
		shr_s <= 12'h000;
		tick(5);
		shr_s <= 12'h001;
		tick(1);
		rdchk("status race", `IOPM_OFS_STATUS, 32'h0);
		xfer(1'b1, `IOPM_OFS_STATUS, 32'hffff_ffff, 4'hf);
		rdchk("status kept", `IOPM_OFS_STATUS, 32'h0000_0001);
		tick(2);
		conclude();
	end
endmodule : io_process_image_mapper_tb
